// ---- delay_timer_pkg.sv ----
// shared constants, mode codes and timer state type for the programmable delay timer
// Function
// - two mode pins pick single pulse, lagged turn-on, lagged turn-off or two-edge lag
// - single pulse: trigger rise drives output low and starts the timer; timeout returns high
// - single pulse: a rise during a running timeout restarts the timer, stretching the pulse
// - single pulse: trigger fall changes neither output nor timer
// - lagged turn-on: trigger rise starts the timer; output goes low at timeout
// - lagged turn-on: trigger fall drives output high at once and cancels the timer
// - lagged turn-off: trigger fall starts the timer; output goes high at timeout
// - lagged turn-off: trigger rise drives output low at once and cancels the timer
// - two-edge lag: either edge starts the timer; timeout drives output to inverse trigger
// - two-edge lag: any edge during a running timeout restarts the timer
// - three-level prescale pick: float gives 1, low and high give variant factors
// - rc variant: source select low takes external clock, high takes internal oscillator
// - reset pin high aborts the timeout and holds the output high
// - reset release with trigger low leaves the output high in every mode
// - release with trigger high in turn-on or two-edge mode starts a timed delay
// - release with trigger high in lagged turn-off mode drives output low at once
// - release with trigger high in single pulse mode keeps output high, no timer
// - delay length comes from eight weight bits, prescale factor and time base rate
// - single pulse low time is prescale times weight time base periods
// - other modes add one half time base period to prescale times weight
// - weight value is the unsigned binary sum, bit n weighing two to the n
package delay_timer_pkg;

  // -------------------------------------------------------------------------
  // widths and codes
  // -------------------------------------------------------------------------
  localparam int unsigned WEIGHT_W = 8;
  localparam int unsigned PRESC_W  = 21;

  localparam logic [1:0] MODE_SINGLE_PULSE = 2'h0; // single_pulse_mode
  localparam logic [1:0] MODE_LAG_TURN_ON  = 2'h1;
  localparam logic [1:0] MODE_LAG_TURN_OFF = 2'h2; // lagged_turn_off_mode
  localparam logic [1:0] MODE_TWO_EDGE     = 2'h3; // two_edge_lag_mode

  // -------------------------------------------------------------------------
  // prescale factors and reset values
  // -------------------------------------------------------------------------
  localparam int unsigned PRESC_FLOAT     = 1;
  localparam int unsigned PRESC_RC_LOW    = 3000;
  localparam int unsigned PRESC_RC_HIGH   = 3600;
  localparam int unsigned PRESC_XTAL_LOW  = 32768;
  localparam int unsigned PRESC_XTAL_HIGH = 32768 * 60;

  localparam logic OUT_RESET = 1'h1;

  // -------------------------------------------------------------------------
  // timer states, gray along idle -> count -> half
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    T_IDLE  = 2'h0,
    T_COUNT = 2'h1,
    T_HALF  = 2'h3
  } timer_state_e;

endpackage

// ---- sync_if.sv ----
// bundle carrying a group of raw pin levels and their filtered levels and edges
`timescale 1ns/1ps
interface sync_if #(parameter int unsigned W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;

  modport filt (input raw, output level, output rise, output fall);
  modport user (output raw, input level, input rise, input fall);
endinterface

// ---- pin_sync.sv ----
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic CLK,
  input  wire logic NRST,
  sync_if.filt      p
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] lvl_r;
  logic [W-1:0] rise_r;
  logic [W-1:0] fall_r;
  logic [W-1:0] agree_w;
  logic [W-1:0] lvl_nxt;

  // a bit counts as changed once stages two and three agree
  assign agree_w = ~(s2_r ^ s3_r);
  assign lvl_nxt = (agree_w & s3_r) | (~agree_w & lvl_r);

  // shift chain; stage one feeds stage two only
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      lvl_r  <= '0;
      rise_r <= '0;
      fall_r <= '0;
    end else begin
      s1_r   <= p.raw;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      lvl_r  <= lvl_nxt;
      rise_r <= lvl_nxt & ~lvl_r;
      fall_r <= ~lvl_nxt & lvl_r;
    end
  end

  assign p.level = lvl_r;
  assign p.rise  = rise_r;
  assign p.fall  = fall_r;

endmodule // pin_sync

// ---- delay_timer.sv ----
// programmable delay timer: mode decode, prescaled down counter and output shaping
`timescale 1ns/1ps
module delay_timer #(
  parameter bit          CRYSTAL_VARIANT = 1'b0,
  parameter int unsigned PRESC_LOW_RC    = delay_timer_pkg::PRESC_RC_LOW,
  parameter int unsigned PRESC_HIGH_RC   = delay_timer_pkg::PRESC_RC_HIGH,
  parameter int unsigned PRESC_LOW_XTAL  = delay_timer_pkg::PRESC_XTAL_LOW,
  parameter int unsigned PRESC_HIGH_XTAL = delay_timer_pkg::PRESC_XTAL_HIGH
) (
  input  wire logic       CLK,
  input  wire logic       NRST,
  input  wire logic       TRIGGER_INPUT,
  input  wire logic       RESET_IN,
  input  wire logic       MODE_A,
  input  wire logic       MODE_B,
  input  wire logic [7:0] WEIGHT_BITS,
  input  wire logic       PRESCALE_FLOAT,
  input  wire logic       PRESCALE_LEVEL,
  input  wire logic       TIMEBASE_SOURCE_SEL,
  input  wire logic       TIMEBASE_IN,
  input  wire logic       OSC_IN,
  input  wire logic       CRYSTAL_TIMEBASE_IN,
  output logic            DELAY_OUT,
  output logic            TIMER_BUSY
);

  localparam int unsigned PW = delay_timer_pkg::PRESC_W;
  localparam int unsigned WW = delay_timer_pkg::WEIGHT_W;

  // -------------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------------
  sync_if #(.W(1))  trigger_input_s ();
  sync_if #(.W(1))  rst_s ();
  sync_if #(.W(3))  clk_s ();
  sync_if #(.W(13)) strap_s ();

  // raw pins into the filters
  assign trigger_input_s.raw  = TRIGGER_INPUT;
  assign rst_s.raw   = RESET_IN;
  assign clk_s.raw   = {CRYSTAL_TIMEBASE_IN, OSC_IN, TIMEBASE_IN};
  assign strap_s.raw = {TIMEBASE_SOURCE_SEL, PRESCALE_FLOAT, PRESCALE_LEVEL,
                        MODE_A, MODE_B, WEIGHT_BITS};

  pin_sync #(.W(1)) u_trigger_input_sync (
    .CLK  (CLK),
    .NRST (NRST),
    .p    (trigger_input_s.filt)
  );

  pin_sync #(.W(1)) u_rst_sync (
    .CLK  (CLK),
    .NRST (NRST),
    .p    (rst_s.filt)
  );

  pin_sync #(.W(3)) u_clk_sync (
    .CLK  (CLK),
    .NRST (NRST),
    .p    (clk_s.filt)
  );

  pin_sync #(.W(13)) u_strap_sync (
    .CLK  (CLK),
    .NRST (NRST),
    .p    (strap_s.filt)
  );

  // -------------------------------------------------------------------------
  // strap decode
  // -------------------------------------------------------------------------
  logic [1:0]    mode_w;
  logic [WW-1:0] weight_w;
  logic          src_sel_w;
  logic          p_float_w;
  logic          p_level_w;
  logic          is_os_w;
  logic          is_on_w;
  logic          is_off_w;
  logic          is_dd_w;

  // mode pins and weight bits from the filtered strap group
  assign src_sel_w = strap_s.level[12];
  assign p_float_w = strap_s.level[11];
  assign p_level_w = strap_s.level[10];
  assign mode_w    = strap_s.level[9:8];
  assign weight_w  = strap_s.level[7:0]; // plain binary sum, bit n weighs 2**n
  assign is_os_w   = (mode_w == delay_timer_pkg::MODE_SINGLE_PULSE);
  assign is_on_w   = (mode_w == delay_timer_pkg::MODE_LAG_TURN_ON);
  assign is_off_w  = (mode_w == delay_timer_pkg::MODE_LAG_TURN_OFF);
  assign is_dd_w   = (mode_w == delay_timer_pkg::MODE_TWO_EDGE);

  // prescale factor from the three-level pick
  logic [PW-1:0] presc_low_w;
  logic [PW-1:0] presc_high_w;
  logic [PW-1:0] presc_w;

  assign presc_low_w  = CRYSTAL_VARIANT ? PW'(PRESC_LOW_XTAL) : PW'(PRESC_LOW_RC);
  assign presc_high_w = CRYSTAL_VARIANT ? PW'(PRESC_HIGH_XTAL) : PW'(PRESC_HIGH_RC);
  assign presc_w      = p_float_w ? PW'(delay_timer_pkg::PRESC_FLOAT) :
                        (p_level_w ? presc_high_w : presc_low_w);

  // time base: crystal pin, or external clock / internal oscillator on rc parts
  logic tb_rise_w;
  logic tb_fall_w;

  assign tb_rise_w = CRYSTAL_VARIANT ? clk_s.rise[2] :
                     (src_sel_w ? clk_s.rise[1] : clk_s.rise[0]);
  assign tb_fall_w = CRYSTAL_VARIANT ? clk_s.fall[2] :
                     (src_sel_w ? clk_s.fall[1] : clk_s.fall[0]);

  // -------------------------------------------------------------------------
  // event decode
  // -------------------------------------------------------------------------
  logic rst_lvl_w;
  logic rst_rel_w;
  logic trigger_input_lvl_w;
  logic t_rise_w;
  logic t_fall_w;
  logic start_w;
  logic cancel_w;

  // trigger edges count only outside reset and outside the release cycle
  assign rst_lvl_w  = rst_s.level[0];
  assign rst_rel_w  = rst_s.fall[0] & ~rst_lvl_w;
  assign trigger_input_lvl_w = trigger_input_s.level[0];
  assign t_rise_w   = trigger_input_s.rise[0] & ~rst_lvl_w & ~rst_rel_w;
  assign t_fall_w   = trigger_input_s.fall[0] & ~rst_lvl_w & ~rst_rel_w;

  // timer start sources; a start while running is a restart
  assign start_w = (rst_rel_w & trigger_input_lvl_w & (is_on_w | is_dd_w))
                 | (t_rise_w & (is_os_w | is_on_w))
                 | (t_fall_w & is_off_w)
                 | ((t_rise_w | t_fall_w) & is_dd_w);
  assign cancel_w = (t_fall_w & is_on_w) | (t_rise_w & is_off_w);

  // -------------------------------------------------------------------------
  // prescale divider and weight down counter
  // -------------------------------------------------------------------------
  delay_timer_pkg::timer_state_e state_r;
  delay_timer_pkg::timer_state_e state_nxt;
  logic [PW-1:0] pre_r;
  logic [PW-1:0] pre_nxt;
  logic [WW-1:0] wcnt_r;
  logic [WW-1:0] wcnt_nxt;
  logic          cnt_end_w;
  logic          timeout_w;

  // counting ends on a zero weight or the last prescaled tick
  assign cnt_end_w = (state_r == delay_timer_pkg::T_COUNT) &&
                     ((wcnt_r == '0) ||
                      (tb_rise_w && (pre_r == '0) && (wcnt_r == WW'(1))));
  assign timeout_w = (cnt_end_w && is_os_w) ||
                     ((state_r == delay_timer_pkg::T_HALF) && tb_fall_w);

  // next state of the timer
  always_comb begin
    state_nxt = state_r;
    pre_nxt   = pre_r;
    wcnt_nxt  = wcnt_r;
    if (rst_lvl_w || cancel_w) begin
      state_nxt = delay_timer_pkg::T_IDLE;
    end else if (start_w) begin
      state_nxt = delay_timer_pkg::T_COUNT;
      pre_nxt   = PW'(presc_w - PW'(1));
      wcnt_nxt  = weight_w;
    end else begin
      case (state_r)
        delay_timer_pkg::T_COUNT: begin
          if (cnt_end_w) begin
            state_nxt = is_os_w ? delay_timer_pkg::T_IDLE : delay_timer_pkg::T_HALF;
          end else if (tb_rise_w) begin
            if (pre_r == '0) begin
              pre_nxt  = PW'(presc_w - PW'(1));
              wcnt_nxt = WW'(wcnt_r - WW'(1));
            end else begin
              pre_nxt = PW'(pre_r - PW'(1));
            end
          end
        end
        delay_timer_pkg::T_HALF: begin
          if (tb_fall_w) begin
            state_nxt = delay_timer_pkg::T_IDLE;
          end
        end
        delay_timer_pkg::T_IDLE: begin
          state_nxt = delay_timer_pkg::T_IDLE;
        end
        default: begin
          state_nxt = delay_timer_pkg::T_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // output shaping
  // -------------------------------------------------------------------------
  logic out_r;
  logic out_nxt;
  logic busy_r;

  // reset first, then release, then immediate edges, then timeout
  always_comb begin
    out_nxt = out_r;
    if (rst_lvl_w) begin
      out_nxt = 1'b1;
    end else if (rst_rel_w) begin
      out_nxt = ~(is_off_w & trigger_input_lvl_w);
    end else if (t_rise_w && (is_os_w || is_off_w)) begin
      out_nxt = 1'b0;
    end else if (t_fall_w && is_on_w) begin
      out_nxt = 1'b1;
    end else if (timeout_w && !start_w) begin
      case (mode_w)
        delay_timer_pkg::MODE_SINGLE_PULSE: out_nxt = 1'b1;
        delay_timer_pkg::MODE_LAG_TURN_ON:  out_nxt = 1'b0;
        delay_timer_pkg::MODE_LAG_TURN_OFF: out_nxt = 1'b1;
        delay_timer_pkg::MODE_TWO_EDGE:     out_nxt = ~trigger_input_lvl_w;
        default:                            out_nxt = out_r;
      endcase
    end
  end

  // state registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state_r <= delay_timer_pkg::T_IDLE;
      pre_r   <= '0;
      wcnt_r  <= '0;
      out_r   <= delay_timer_pkg::OUT_RESET;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pre_r   <= pre_nxt;
      wcnt_r  <= wcnt_nxt;
      out_r   <= out_nxt;
      busy_r  <= (state_nxt != delay_timer_pkg::T_IDLE);
    end
  end

  assign DELAY_OUT  = out_r;
  assign TIMER_BUSY = busy_r;

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence s_release_high;
    rst_rel_w && trigger_input_lvl_w;
  endsequence

  sequence s_idle_high;
    out_r && (state_r == delay_timer_pkg::T_IDLE);
  endsequence

  a_reset_holds_high: assert property (rst_lvl_w [*2] |=> s_idle_high)
    else $error("output not high while reset pin held");

  a_pulse_rise_low: assert property (t_rise_w && is_os_w |=> !out_r && busy_r)
    else $error("single pulse rise did not drive output low");

  a_pulse_fall_none: assert property (t_fall_w && is_os_w && !timeout_w |=> $stable(out_r))
    else $error("single pulse fall changed output");

  a_on_fall_high: assert property (t_fall_w && is_on_w |=> s_idle_high)
    else $error("turn-on fall did not force output high");

  a_off_rise_low: assert property (t_rise_w && is_off_w |=> !out_r && !busy_r)
    else $error("turn-off rise did not force output low");

  a_dd_inverse: assert property (timeout_w && !start_w && !rst_lvl_w && !rst_rel_w
                                 && is_dd_w |=> out_r == !$past(trigger_input_lvl_w))
    else $error("two-edge timeout did not invert trigger");

  a_restart_loads: assert property (start_w && !rst_lvl_w && !cancel_w
                                    |=> wcnt_r == $past(weight_w) && busy_r)
    else $error("restart did not reload weight counter");

  a_release_off_low: assert property (s_release_high ##0 is_off_w |=> !out_r)
    else $error("turn-off release with trigger high not low");

  a_release_os_idle: assert property (s_release_high ##0 is_os_w |=> s_idle_high)
    else $error("single pulse release started a timeout");

  a_release_on_arms: assert property (s_release_high ##0 (is_on_w || is_dd_w)
                                      |=> busy_r && out_r)
    else $error("release with trigger high did not arm the timer");

  a_zero_weight_fast: assert property (start_w && is_os_w && weight_w == '0 && !rst_lvl_w
                                       ##1 !t_rise_w && !rst_lvl_w |=> out_r)
    else $error("zero weight pulse did not end at once");

  // -------------------------------------------------------------------------
  // arming, timeout and reset checks
  // -------------------------------------------------------------------------
  // no reset, release, cancel or start in this cycle
  sequence s_quiet;
    !rst_lvl_w && !rst_rel_w && !cancel_w && !start_w;
  endsequence

  a_on_fall_idle: assert property (t_fall_w && is_on_w |=> !busy_r)
    else $error("turn-on fall did not cancel the timer");

  a_off_fall_arms: assert property (t_fall_w && is_off_w |=> busy_r)
    else $error("turn-off fall did not start the timer");

  a_on_rise_arms: assert property (t_rise_w && is_on_w |=> busy_r && $stable(out_r))
    else $error("turn-on rise did not start the timer quietly");

  a_dd_edge_arms: assert property ((t_rise_w || t_fall_w) && is_dd_w
                                   |=> busy_r && $stable(out_r))
    else $error("two-edge trigger edge did not start the timer");

  a_os_timeout_high: assert property (s_quiet ##0 (timeout_w && is_os_w)
                                      |=> out_r && !busy_r)
    else $error("single pulse timeout did not return output high");

  a_on_timeout_low: assert property (s_quiet ##0 (timeout_w && is_on_w) |=> !out_r)
    else $error("turn-on timeout did not drive output low");

  a_off_timeout_high: assert property (s_quiet ##0 (timeout_w && is_off_w) |=> out_r)
    else $error("turn-off timeout did not drive output high");

  a_busy_in_reset: assert property (rst_lvl_w |=> !busy_r)
    else $error("timer still busy while reset pin held");

  a_half_after_count: assert property (s_quiet ##0 (cnt_end_w && !is_os_w)
                                       |=> state_r == delay_timer_pkg::T_HALF)
    else $error("count end did not enter the half period wait");

  a_half_waits_fall: assert property (s_quiet ##0
                                      (state_r == delay_timer_pkg::T_HALF && !tb_fall_w)
                                      |=> state_r == delay_timer_pkg::T_HALF)
    else $error("half period wait ended before a time base fall");

endmodule // delay_timer

// ---- timebase_model.sv ----
// partner model: external time base line and internal oscillator, one running at a time
`timescale 1ns/1ps
module timebase_model #(
  parameter int unsigned HALF = 8
) (
  input  wire logic CLK,
  input  wire logic USE_OSC,
  output logic      TB_EXT,
  output logic      TB_OSC
);
  int unsigned cnt;
  logic        phase_r;

  initial begin
    cnt = 0;
    phase_r = 1'h0;
    TB_EXT = 1'h0;
    TB_OSC = 1'h0;
  end

  // square wave locked to the system clock so tick phase is repeatable;
  // the source not selected stands still low, as an unused clock would
  always @(posedge CLK) begin
    #1;
    if (cnt == HALF - 1) begin
      cnt = 0;
      phase_r = ~phase_r;
    end else begin
      cnt++;
    end
    TB_EXT = USE_OSC ? 1'h0 : phase_r;
    TB_OSC = USE_OSC ? phase_r : 1'h0;
  end
endmodule // timebase_model

// ---- programmable_delay_timer_tb_top.sv ----
// self-checking testbench for the programmable delay timer
`timescale 1ns/1ps
module programmable_delay_timer_tb_top;
  // ---------------------------------------------------------------------------
  // settings and signals
  // ---------------------------------------------------------------------------
  localparam int HALF = 8;   // time base half period in clock cycles
  localparam int PER  = 16;  // time base period in clock cycles
  localparam int IMM  = 5;   // pin to output latency for immediate actions
  localparam int TOL  = 4;   // allowed spread around an expected count
  logic       clk;
  logic       nrst;
  logic       trigger_input;
  logic       rst_in;
  logic [1:0] mode;
  logic [7:0] weight;
  logic       p_float;
  logic       p_level;
  logic       src_sel;
  logic       tb_ext;
  logic       tb_osc;
  logic       dly_out;
  logic       busy;
  int         failures;
  int         samples_checked;
  wire        tb_any = tb_ext | tb_osc;
  logic [7:0] wl [4] = '{8'h00, 8'h01, 8'h06, 8'hff};

  always #2.5 clk = ~clk;

  timebase_model #(.HALF(HALF)) u_tbm (
    .CLK(clk), .USE_OSC(src_sel), .TB_EXT(tb_ext), .TB_OSC(tb_osc));

  delay_timer #(.PRESC_LOW_RC(2), .PRESC_HIGH_RC(3)) u_dut (
    .CLK(clk), .NRST(nrst), .TRIGGER_INPUT(trigger_input), .RESET_IN(rst_in),
    .MODE_A(mode[1]), .MODE_B(mode[0]), .WEIGHT_BITS(weight),
    .PRESCALE_FLOAT(p_float), .PRESCALE_LEVEL(p_level),
    .TIMEBASE_SOURCE_SEL(src_sel), .TIMEBASE_IN(tb_ext), .OSC_IN(tb_osc),
    .CRYSTAL_TIMEBASE_IN(1'h0), .DELAY_OUT(dly_out), .TIMER_BUSY(busy));

  // ---------------------------------------------------------------------------
  // checking and driving tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int n, input int lo, input int hi);
    samples_checked++;
    if (n < lo || n > hi) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
    end
  endtask

  // which 0 drives the trigger pin, 1 the abort pin, k edges on
  task automatic drive(input bit which, input logic v, input int k);
    repeat (k) @(posedge clk);
    #1;
    if (which) rst_in = v;
    else trigger_input = v;
  endtask

  // line up with a rising time base edge so tick phase is known
  task automatic sync_tb();
    @(posedge tb_any);
    @(posedge clk);
  endtask

  task automatic setm(input logic [1:0] m);
    @(posedge clk);
    #1;
    mode = m;
    repeat (8) @(posedge clk);
  endtask

  // cycles until the output reaches v, compared with an expected count
  task automatic out_after(input logic v, input int centre);
    int n;
    n = 0;
    while (dly_out !== v && n < centre + 2 * TOL) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_rng(n, centre - TOL, centre + TOL);
  endtask

  task automatic hold(input logic v, input int k);
    int bad;
    bad = 0;
    repeat (k) begin
      @(posedge clk);
      #1;
      if (dly_out !== v) bad++;
    end
    chk(bad, 0);
  endtask

  function automatic int dly(input int w);
    return w * PER + HALF + 5;
  endfunction

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs roughly 7000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    $display("[ERR] t=%0t watchdog got=%h exp=%h", $time, 1'h1, 1'h0);
    wrap_up();
  end

  // ---------------------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'h0;
    nrst = 1'h0;
    trigger_input = 1'h0;
    rst_in = 1'h0;
    mode = delay_timer_pkg::MODE_SINGLE_PULSE;
    weight = 8'h03;
    p_float = 1'h1;
    p_level = 1'h0;
    src_sel = 1'h0;
    failures = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'h1;
    @(posedge clk);
    #1;
    chk(dly_out, 1'h1);
    chk(busy, 1'h0);
    // single pulse over boundary weights, then a fall that must do nothing
    foreach (wl[i]) begin
      weight = wl[i];
      repeat (8) @(posedge clk);
      sync_tb();
      drive(0, 1'h1, 0);
      out_after(1'h0, IMM);
      out_after(1'h1, wl[i] * PER);
      chk(busy, 1'h0);
      drive(0, 1'h0, 2);
      hold(1'h1, 4 * PER);
    end
    weight = 8'h03;
    // a second rise during the pulse restarts the count
    sync_tb();
    drive(0, 1'h1, 0);
    drive(0, 1'h0, PER);
    drive(0, 1'h1, PER);
    out_after(1'h1, 3 * PER + 4);
    drive(0, 1'h0, 2);
    // lagged turn-on: timed low, immediate high, cancelled timeout
    setm(delay_timer_pkg::MODE_LAG_TURN_ON);
    sync_tb();
    drive(0, 1'h1, 0);
    hold(1'h1, PER);
    chk(busy, 1'h1);
    out_after(1'h0, dly(3) - PER);
    drive(0, 1'h0, 2);
    out_after(1'h1, IMM);
    sync_tb();
    drive(0, 1'h1, 0);
    drive(0, 1'h0, PER);
    hold(1'h1, 5 * PER);
    // lagged turn-off: immediate low, timed high, cancelled timeout
    setm(delay_timer_pkg::MODE_LAG_TURN_OFF);
    drive(0, 1'h1, 0);
    out_after(1'h0, IMM);
    sync_tb();
    drive(0, 1'h0, 0);
    out_after(1'h1, dly(3));
    sync_tb();
    drive(0, 1'h1, 0);
    out_after(1'h0, IMM);
    sync_tb();
    drive(0, 1'h0, 0);
    drive(0, 1'h1, PER);
    hold(1'h0, 5 * PER);
    // abort pin: forces high, ignores trigger edges meanwhile
    drive(1, 1'h1, 1);
    out_after(1'h1, IMM);
    drive(0, 1'h0, 2);
    drive(0, 1'h1, 2 * PER);
    hold(1'h1, 2 * PER);
    // two-edge lag: both edges timed, later edges restart
    setm(delay_timer_pkg::MODE_TWO_EDGE);
    drive(0, 1'h0, 0);
    drive(1, 1'h0, 2);
    hold(1'h1, 2 * PER);
    sync_tb();
    drive(0, 1'h1, 0);
    out_after(1'h0, dly(3));
    sync_tb();
    drive(0, 1'h0, 0);
    out_after(1'h1, dly(3));
    sync_tb();
    drive(0, 1'h1, 0);
    drive(0, 1'h0, PER);
    drive(0, 1'h1, PER);
    out_after(1'h0, dly(3));
    // release of the abort pin in every mode with the trigger low and high
    for (int m = 0; m < 4; m++) begin
      for (int t = 0; t < 2; t++) begin
        drive(1, 1'h1, 1);
        setm(m[1:0]);
        drive(0, t[0], 2);
        repeat (8) @(posedge clk);
        sync_tb();
        drive(1, 1'h0, 0);
        if (t == 0 || m == 0) begin
          hold(1'h1, 5 * PER);
        end else if (m == 2) begin
          out_after(1'h0, IMM);
        end else begin
          out_after(1'h0, dly(3));
        end
      end
    end
    // prescale pick low and high factors in single pulse mode
    drive(1, 1'h1, 1);
    setm(delay_timer_pkg::MODE_SINGLE_PULSE);
    drive(0, 1'h0, 0);
    drive(1, 1'h0, 2);
    p_float = 1'h0;
    for (int s = 0; s < 3; s++) begin
      p_level = s[0];
      src_sel = s[1];
      repeat (8) @(posedge clk);
      sync_tb();
      drive(0, 1'h1, 0);
      out_after(1'h0, IMM);
      out_after(1'h1, (2 + s[0]) * 3 * PER);
      drive(0, 1'h0, 2);
    end
    wrap_up();
  end
endmodule // programmable_delay_timer_tb_top
